// >>> core/agc_ctrl.sv
/*
 Adaptive gate current controller for four half-bridges with an AHB-Lite register slave.
 Assumes PWM inputs and the switching-done comparators are synchronous to ref_clk_i.
*/
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
// Overview of operation
// [R1] Adapt codes when select is 10 or 11.
// [R2] Target delays come from two registers.
// [R3] Measured delays readable per half-bridge.
// [R4] Pre-charge code clamped between minimum and maximum.
// [R5] Pre-discharge code clamped between minimum and maximum.
// [R6] Pre-charge lasts configured per-bridge duration.
// [R7] Pre-discharge lasts configured per-bridge duration.
// [R8] Start codes come from initial registers.
// [R9] Charge and discharge currents follow pre-phases.
// [R10] Freewheel MOSFET uses its own current.
// [R11] Hard-off sink uses discharge code 63.
// [R12] Hold current level set by control bit.
// [R13] Enable write loads min of start, maximum.
// [R14] Unfiltered: step toward target every cycle.
// [R15] Filtered: step only after two agreeing misses.
// [R16] Step bit selects one or two steps.
// [R17] Each half-bridge keeps independent adaptation state.
// [R18] Updates saturate at limits, never wrap.
`timescale 1ns/1ps
module agc_ctrl
   import agc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [NHB-1:0] pwm_i,
   input wire logic [NHB-1:0] ton_done_i,
   input wire logic [NHB-1:0] toff_done_i,
   output logic [6*NHB-1:0] gate_code_o,
   output logic [NHB-1:0] gate_sink_o,
   output logic [6*NHB-1:0] fw_code_o,
   output logic [NHB-1:0] fw_sink_o,
   output logic hold_current_o
);
   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [5:0] clamp(input logic [6:0] v, input logic [5:0] mx);
      logic [6:0] r;
      r = (v > {1'b0, mx}) ? {1'b0, mx} : v;
      if (r < {1'b0, MIN_CODE}) begin
         r = {1'b0, MIN_CODE};
      end
      return r[5:0];
   endfunction

   function automatic agc_dir_t err_dir(input logic [7:0] meas, input logic [7:0] tgt);
      agc_dir_t d;
      d = DIR_NONE;
      if (meas > tgt) begin
         d = DIR_UP;
      end else if (meas < tgt) begin
         d = DIR_DN;
      end
      return d;
   endfunction

   function automatic logic [5:0] adapt(input logic [5:0] code, input agc_dir_t d, input agc_dir_t pd,
                                        input logic filt, input logic two, input logic [5:0] mx);
      logic [6:0] st;
      logic [6:0] v;
      st = two ? 7'h02 : 7'h01; // [R16]
      v = {1'b0, code};
      if (filt && (d != pd)) begin
         v = {1'b0, code}; // [R15]
      end else if (d == DIR_UP) begin
         v = {1'b0, code} + st; // [R14]
      end else if (d == DIR_DN) begin
         v = ({1'b0, code} > st) ? ({1'b0, code} - st) : 7'h00; // [R18]
      end
      return clamp(v, mx);
   endfunction

   // ************************************************************
   // Registers and AHB-Lite slave
   // ************************************************************
   logic [31:0] gen_reg, ton_reg, toff_reg, imax_reg, pinit_reg, dinit_reg, tpre_reg, ichg_reg;
   logic [NHB-1:0] pwm_en;
   logic [7:0] meas_on [NHB];
   logic [7:0] meas_off [NHB];
   logic [5:0] pre_code [NHB];
   logic [5:0] pdis_code [NHB];
   logic wr_pend, rd_pend;
   logic [7:0] addr_q;
   logic [31:0] rmux;
   logic [NHB-1:0] en_load;
   logic take;

   assign take = hsel_i && htrans_i[1] && hready_i;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q <= 8'h00;
         hreadyout_o <= 1'b1;
         hrdata_o <= 32'h0000_0000;
      end else begin
         wr_pend <= take && hwrite_i;
         rd_pend <= take && !hwrite_i;
         if (take) begin
            addr_q <= haddr_i[7:0];
         end
         // A read waits one cycle so a write just before it is already visible.
         hreadyout_o <= !(take && !hwrite_i);
         if (rd_pend) begin
            hrdata_o <= rmux;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hresp_o <= 1'b0;
      end else begin
         hresp_o <= 1'b0;
      end
   end

   always_comb begin
      rmux = 32'h0000_0000;
      case (addr_q)
         A_GEN: rmux = gen_reg;
         A_PWMEN: rmux = {28'h000_0000, pwm_en};
         A_TON: rmux = ton_reg;
         A_TOFF: rmux = toff_reg;
         A_IMAX: rmux = imax_reg;
         A_PINIT: rmux = pinit_reg;
         A_DINIT: rmux = dinit_reg;
         A_TPRE: rmux = tpre_reg;
         A_ICHG: rmux = ichg_reg;
         default: rmux = 32'h0000_0000;
      endcase
      for (int i = 0; i < NHB; i++) begin
         if (addr_q == A_MEAS0 + 8'(4 * i)) begin
            rmux = {16'h0000, meas_off[i], meas_on[i]}; // [R3]
         end
         if (addr_q == A_PCODE) begin
            rmux[8*i+:8] = {2'b00, pre_code[i]};
         end
         if (addr_q == A_DCODE) begin
            rmux[8*i+:8] = {2'b00, pdis_code[i]};
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gen_reg <= RST_GEN;
         pwm_en <= 4'h0;
         ton_reg <= RST_TGT;
         toff_reg <= RST_TGT;
         imax_reg <= RST_IMAX;
         pinit_reg <= RST_INIT;
         dinit_reg <= RST_INIT;
         tpre_reg <= RST_TPRE;
         ichg_reg <= RST_ICHG;
      end else if (wr_pend) begin
         case (addr_q)
            A_GEN: gen_reg <= {27'h000_0000, hwdata_i[4:0]};
            A_PWMEN: pwm_en <= hwdata_i[3:0];
            A_TON: ton_reg <= hwdata_i; // [R2]
            A_TOFF: toff_reg <= hwdata_i; // [R2]
            A_IMAX: imax_reg <= hwdata_i & 32'h3F3F_3F3F;
            A_PINIT: pinit_reg <= hwdata_i & 32'h3F3F_3F3F;
            A_DINIT: dinit_reg <= hwdata_i & 32'h3F3F_3F3F;
            A_TPRE: tpre_reg <= hwdata_i;
            A_ICHG: ichg_reg <= hwdata_i & 32'h003F_3F3F;
            default: ;
         endcase
      end
   end

   assign en_load = (wr_pend && addr_q == A_PWMEN) ? (hwdata_i[3:0] & ~pwm_en) : 4'h0;

   // ************************************************************
   // Per half-bridge sequencing
   // ************************************************************
   agc_phase_t phase [NHB];
   logic [3:0] tmr [NHB];
   logic [7:0] cnt [NHB];
   logic [NHB-1:0] pwm_q, on_done, off_done, rise, fall;
   agc_dir_t pdir_on [NHB];
   agc_dir_t pdir_off [NHB];
   logic adapt_on;

   assign adapt_on = gen_reg[GEN_SEL+1]; // [R1]
   assign rise = pwm_i & ~pwm_q;
   assign fall = ~pwm_i & pwm_q;

   always_comb begin
      for (int i = 0; i < NHB; i++) begin
         on_done[i] = (phase[i] == PH_PRECHG || phase[i] == PH_CHG) && ton_done_i[i] && !fall[i];
         off_done[i] = (phase[i] == PH_PREDCHG || phase[i] == PH_DCHG) && toff_done_i[i] && !rise[i];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_q <= 4'h0;
         for (int i = 0; i < NHB; i++) begin
            phase[i] <= PH_OFF;
            tmr[i] <= 4'h0;
            cnt[i] <= 8'h00;
         end
      end else begin
         pwm_q <= pwm_i;
         for (int i = 0; i < NHB; i++) begin
            // The delay counter saturates so a missing comparator edge reads as a long delay.
            cnt[i] <= (rise[i] || fall[i]) ? 8'h00 : ((cnt[i] == CNT_MAX) ? CNT_MAX : cnt[i] + 8'h01);
            if (!pwm_en[i]) begin
               phase[i] <= PH_OFF;
            end else if (rise[i] || (phase[i] == PH_OFF && pwm_i[i])) begin
               if (gen_reg[GEN_SEL+:2] != 2'b00 && tpre_reg[8*i+:4] != 4'h0) begin
                  phase[i] <= PH_PRECHG; // [R6]
                  tmr[i] <= tpre_reg[8*i+:4] - 4'h1;
               end else begin
                  phase[i] <= PH_CHG;
               end
            end else if (fall[i] || (phase[i] == PH_OFF && !pwm_i[i])) begin
               if (gen_reg[GEN_SEL+:2] != 2'b00 && tpre_reg[8*i+4+:4] != 4'h0 && phase[i] != PH_OFF) begin
                  phase[i] <= PH_PREDCHG; // [R7]
                  tmr[i] <= tpre_reg[8*i+4+:4] - 4'h1;
               end else begin
                  if (phase[i] == PH_OFF) begin
                     phase[i] <= PH_HOLD_OFF;
                  end else begin
                     phase[i] <= PH_DCHG;
                  end
               end
            end else if (on_done[i]) begin
               phase[i] <= PH_HOLD_ON;
            end else if (off_done[i]) begin
               phase[i] <= PH_HOLD_OFF;
            end else if (phase[i] == PH_PRECHG || phase[i] == PH_PREDCHG) begin
               tmr[i] <= tmr[i] - 4'h1;
               if (tmr[i] == 4'h0) begin
                  if (phase[i] == PH_PRECHG) begin
                     phase[i] <= PH_CHG; // [R9]
                  end else begin
                     phase[i] <= PH_DCHG; // [R9]
                  end
               end
            end
         end
      end
   end

   // ************************************************************
   // Delay capture and code adaptation
   // ************************************************************
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NHB; i++) begin
            meas_on[i] <= 8'h00;
            meas_off[i] <= 8'h00;
            pre_code[i] <= MIN_CODE;
            pdis_code[i] <= MIN_CODE;
            pdir_on[i] <= DIR_NONE;
            pdir_off[i] <= DIR_NONE;
         end
      end else begin
         for (int i = 0; i < NHB; i++) begin // [R17]
            if (en_load[i]) begin
               pre_code[i] <= clamp({1'b0, pinit_reg[8*i+:6]}, imax_reg[8*i+:6]); // [R13] [R8] [R4]
               pdis_code[i] <= clamp({1'b0, dinit_reg[8*i+:6]}, imax_reg[8*i+:6]); // [R13] [R8] [R5]
               pdir_on[i] <= DIR_NONE;
               pdir_off[i] <= DIR_NONE;
            end else begin
               if (on_done[i]) begin
                  meas_on[i] <= cnt[i];
                  if (adapt_on) begin
                     pre_code[i] <= adapt(pre_code[i], err_dir(cnt[i], ton_reg[8*i+:8]), pdir_on[i],
                                          gen_reg[GEN_FILT], gen_reg[GEN_STEP], imax_reg[8*i+:6]); // [R4] [R14]
                     pdir_on[i] <= err_dir(cnt[i], ton_reg[8*i+:8]);
                  end
               end
               if (off_done[i]) begin
                  meas_off[i] <= cnt[i];
                  if (adapt_on) begin
                     pdis_code[i] <= adapt(pdis_code[i], err_dir(cnt[i], toff_reg[8*i+:8]), pdir_off[i],
                                           gen_reg[GEN_FILT], gen_reg[GEN_STEP], imax_reg[8*i+:6]); // [R5] [R14]
                     pdir_off[i] <= err_dir(cnt[i], toff_reg[8*i+:8]);
                  end
               end
            end
         end
      end
   end

   // ************************************************************
   // Gate current outputs
   // ************************************************************
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gate_code_o <= {NHB{HARDOFF_CODE}};
         gate_sink_o <= 4'hF;
         fw_code_o <= {NHB{HARDOFF_CODE}};
         fw_sink_o <= 4'hF;
         hold_current_o <= 1'b0;
      end else begin
         hold_current_o <= gen_reg[GEN_HOLD]; // [R12]
         for (int i = 0; i < NHB; i++) begin
            fw_code_o[6*i+:6] <= (phase[i] == PH_OFF) ? HARDOFF_CODE : ichg_reg[ICHG_FW+:6]; // [R10]
            fw_sink_o[i] <= (phase[i] != PH_HOLD_OFF);
            gate_sink_o[i] <= phase[i][2] || (phase[i] == PH_OFF);
            case (phase[i])
               PH_OFF: gate_code_o[6*i+:6] <= HARDOFF_CODE; // [R11]
               PH_PRECHG: gate_code_o[6*i+:6] <= pre_code[i]; // [R6]
               PH_CHG: gate_code_o[6*i+:6] <= ichg_reg[ICHG_CHG+:6]; // [R9]
               PH_PREDCHG: gate_code_o[6*i+:6] <= pdis_code[i]; // [R7]
               PH_DCHG: gate_code_o[6*i+:6] <= ichg_reg[ICHG_DIS+:6]; // [R9]
               PH_HOLD_ON, PH_HOLD_OFF: gate_code_o[6*i+:6] <= gen_reg[GEN_HOLD] ? HOLD_HI_CODE : HOLD_LO_CODE; // [R12]
               default: gate_code_o[6*i+:6] <= HARDOFF_CODE;
            endcase
         end
      end
   end
endmodule

// >>> core/agc_pkg.sv
/*
 Constants, register map and types of the adaptive gate current controller.
 Assumes a 32-bit AHB-Lite register bus and four half-bridges.
*/
package agc_pkg;
   localparam int NHB = 4;
   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [7:0] A_GEN = 8'h00;
   localparam logic [7:0] A_PWMEN = 8'h04;
   localparam logic [7:0] A_TON = 8'h08;
   localparam logic [7:0] A_TOFF = 8'h0C;
   localparam logic [7:0] A_IMAX = 8'h10;
   localparam logic [7:0] A_PINIT = 8'h14;
   localparam logic [7:0] A_DINIT = 8'h18;
   localparam logic [7:0] A_TPRE = 8'h1C;
   localparam logic [7:0] A_ICHG = 8'h20;
   localparam logic [7:0] A_MEAS0 = 8'h30;
   localparam logic [7:0] A_PCODE = 8'h40;
   localparam logic [7:0] A_DCODE = 8'h44;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int GEN_SEL = 0;
   localparam int GEN_FILT = 2;
   localparam int GEN_STEP = 3;
   localparam int GEN_HOLD = 4;
   localparam int ICHG_CHG = 0;
   localparam int ICHG_DIS = 8;
   localparam int ICHG_FW = 16;
   // ************************************************************
   // Current codes and reset values
   // ************************************************************
   localparam logic [5:0] MIN_CODE = 6'h01;
   localparam logic [5:0] HARDOFF_CODE = 6'h3F;
   localparam logic [5:0] HOLD_LO_CODE = 6'h02;
   localparam logic [5:0] HOLD_HI_CODE = 6'h08;
   localparam logic [31:0] RST_GEN = 32'h0000_0002;
   localparam logic [31:0] RST_TGT = 32'h2020_2020;
   localparam logic [31:0] RST_IMAX = 32'h3F3F_3F3F;
   localparam logic [31:0] RST_INIT = 32'h1010_1010;
   localparam logic [31:0] RST_TPRE = 32'h4444_4444;
   localparam logic [31:0] RST_ICHG = 32'h0010_1010;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      PH_OFF = 3'b000,
      PH_PRECHG = 3'b001,
      PH_CHG = 3'b010,
      PH_HOLD_ON = 3'b011,
      PH_PREDCHG = 3'b100,
      PH_DCHG = 3'b101,
      PH_HOLD_OFF = 3'b110
   } agc_phase_t;
   typedef enum logic [1:0] {
      DIR_NONE = 2'b00,
      DIR_UP = 2'b01,
      DIR_DN = 2'b10
   } agc_dir_t;
endpackage

// >>> verif/agc_ctrl_properties.sv
/*
 Concurrent checks on the bus answer and the gate outputs of agc_ctrl.
 Assumes it is bound to agc_ctrl and sees only that module's ports.
*/
`timescale 1ns/1ps
module agc_ctrl_properties
   import agc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [NHB-1:0] pwm_i,
   input wire logic [6*NHB-1:0] gate_code_o,
   input wire logic [NHB-1:0] gate_sink_o,
   input wire logic [NHB-1:0] fw_sink_o,
   input wire logic hold_current_o
);
   logic take, gen_q, chk, hold_d, unm_q;
   assign take = hsel_i & htrans_i[1] & hready_i;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gen_q <= 1'h0;
         chk <= 1'h0;
         hold_d <= 1'h0;
         unm_q <= 1'h0;
      end else begin
         gen_q <= take & hwrite_i & (haddr_i[7:0] == A_GEN);
         chk <= gen_q;
         if (gen_q) begin
            hold_d <= hwdata_i[GEN_HOLD];
         end
         unm_q <= take & !hwrite_i & (haddr_i[7:0] >= 8'h48);
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   bus_okay_a: assert property (hresp_o == 1'h0) else $error("response not okay");
   rd_wait_a: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait wrong");
   rd_only_a: assert property (!hreadyout_o |-> $past(take && !hwrite_i)) else $error("stray wait state");
   rd_stable_a: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o)) else $error("rdata moved");
   unmapped_zero_a: assert property (unm_q |=> hrdata_o == 32'h0) else $error("unmapped read not zero");
   hold_follow_a: assert property (chk |-> ##[0:1] hold_current_o == hold_d) else $error("hold level wrong");
   fw_on_sink_a: assert property ((~fw_sink_o & ~gate_sink_o) == 4'h0) else $error("freewheel on while sourcing");
   rst_hard_off_a: assert property ($rose(rst_n_i) |->
      gate_code_o == {NHB{HARDOFF_CODE}} && gate_sink_o == 4'hF) else $error("not hard off after reset");
   src_on_pwm_a: assert property ($fell(gate_sink_o[0]) |-> $past(pwm_i[0])) else $error("source without pwm");
endmodule
bind agc_ctrl agc_ctrl_properties u_agc_ctrl_properties (.ref_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i,
   .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .pwm_i, .gate_code_o, .gate_sink_o,
   .fw_sink_o, .hold_current_o);

// >>> verif/agc_fet_model.sv
/*
 Behavioural model of the external MOSFETs and their switching comparators.
 Assumes the done levels are read synchronously to ref_clk_i.
*/
`timescale 1ns/1ps
module agc_fet_model
   import agc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [NHB-1:0] pwm_i,
   input wire logic [7:0] on_dly_i,
   input wire logic [7:0] off_dly_i,
   output logic [NHB-1:0] ton_done_o,
   output logic [NHB-1:0] toff_done_o
);
   logic [NHB-1:0] prev;
   logic [7:0] cnt [NHB];
   // The delay is fixed by the bench, so it can answer promptly or slowly.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev <= '0;
         for (int i = 0; i < NHB; i++) cnt[i] <= 8'h00;
      end else begin
         prev <= pwm_i;
         for (int i = 0; i < NHB; i++) cnt[i] <= (pwm_i[i] != prev[i]) ? 8'h00 : cnt[i] + {7'h00, cnt[i] != 8'hFF};
      end
   end
   always_comb begin
      for (int i = 0; i < NHB; i++) begin
         ton_done_o[i] = pwm_i[i] & prev[i] & (cnt[i] >= on_dly_i);
         toff_done_o[i] = !pwm_i[i] & !prev[i] & (cnt[i] >= off_dly_i);
      end
   end
endmodule

// >>> verif/agc_ctrl_tb.sv
/*
 Self-checking bench of agc_ctrl with an AHB-Lite master and the MOSFET model.
 Assumes the slave answers reads with one wait state and writes with none.
*/
`timescale 1ns/1ps
module agc_ctrl_tb
   import agc_pkg::*;
;
   logic ref_clk_i = 1'h0, rst_n_i = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hold;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [NHB-1:0] pwm = 4'h0, ton_done, toff_done, gate_sink, fw_sink;
   logic [6*NHB-1:0] gate_code, fw_code;
   int errors = 0, samples_checked = 0;
   initial begin
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   agc_ctrl u_agc_ctrl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(), .pwm_i(pwm), .ton_done_i(ton_done), .toff_done_i(toff_done),
      .gate_code_o(gate_code), .gate_sink_o(gate_sink), .fw_code_o(fw_code), .fw_sink_o(fw_sink),
      .hold_current_o(hold));
   agc_fet_model u_agc_fet_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pwm_i(pwm), .on_dly_i(8'h28),
      .off_dly_i(8'h0A), .ton_done_o(ton_done), .toff_done_o(toff_done));
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Ready is read at the falling edge, where it holds the value the next rising edge samples.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic r;
      @(posedge ref_clk_i);
      hsel <= 1'h1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do begin @(negedge ref_clk_i); r = hready; @(posedge ref_clk_i); end while (r !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(negedge ref_clk_i); r = hready; rd = hrdata; @(posedge ref_clk_i); end while (r !== 1'h1);
   endtask
   task automatic en(input logic [31:0] v);
      bus(1'h1, A_PWMEN, 32'h0);
      bus(1'h1, A_PWMEN, v);
   endtask
   task automatic pulse();
      pwm[0] <= 1'h1;
      repeat (80) @(posedge ref_clk_i);
      pwm[0] <= 1'h0;
      repeat (80) @(posedge ref_clk_i);
   endtask
   task automatic stop_test();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_regs();
      bus(1'h0, A_GEN, 32'h0); check("gen reset", rd, RST_GEN);
      bus(1'h0, A_TON, 32'h0); check("ton reset", rd, RST_TGT);
      bus(1'h1, 8'h48, 32'hFFFF_FFFF); bus(1'h0, 8'h48, 32'h0); check("unmapped", rd, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_load();
      bus(1'h1, A_IMAX, 32'h3F3F_3F08); bus(1'h1, A_DINIT, 32'h1010_1003); en(32'h3);
      bus(1'h0, A_PCODE, 32'h0); check("pcode load", rd & 32'hFF, 32'h08);
      bus(1'h0, A_DCODE, 32'h0); check("dcode load", rd & 32'hFF, 32'h03);
      bus(1'h1, A_IMAX, RST_IMAX); bus(1'h1, A_DINIT, RST_INIT); en(32'h3);
      $display("test load done");
   endtask
   task automatic t_adapt();
      pulse(); bus(1'h0, A_MEAS0, 32'h0); check("meas", rd & 32'hFFFF, 32'h0A28);
      bus(1'h0, A_PCODE, 32'h0); check("pcode up", rd & 32'hFFFF, 32'h1011);
      bus(1'h0, A_DCODE, 32'h0); check("dcode down", rd & 32'hFF, 32'h0F);
      bus(1'h1, A_GEN, 32'h0A); pulse(); bus(1'h0, A_PCODE, 32'h0); check("pcode two", rd & 32'hFF, 32'h13);
      bus(1'h1, A_TON, 32'h2020_2028); pulse();
      bus(1'h0, A_PCODE, 32'h0); check("pcode on target", rd & 32'hFF, 32'h13);
      bus(1'h1, A_TON, RST_TGT);
      $display("test adapt done");
   endtask
   task automatic t_clamp();
      bus(1'h1, A_IMAX, 32'h3F3F_3F14); bus(1'h1, A_DINIT, 32'h1010_1002); en(32'h1);
      repeat (3) pulse();
      bus(1'h0, A_PCODE, 32'h0); check("pcode max", rd & 32'hFF, 32'h14);
      bus(1'h0, A_DCODE, 32'h0); check("dcode min", rd & 32'hFF, 32'h01);
      $display("test clamp done");
   endtask
   task automatic t_gate();
      bus(1'h1, A_GEN, 32'h1A);
      bus(1'h1, A_ICHG, 32'h0025_1A10);
      pwm[0] <= 1'h1;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i); check("precharge", {gate_sink[0], gate_code[5:0]}, 32'h14);
      repeat (5) @(posedge ref_clk_i);
      @(negedge ref_clk_i); check("charge", {gate_sink[0], gate_code[5:0]}, 32'h10);
      repeat (60) @(posedge ref_clk_i);
      @(negedge ref_clk_i); check("hold", {hold, gate_code[5:0]}, {25'h0, 1'h1, HOLD_HI_CODE});
      check("fw off", {fw_sink[0], fw_code[5:0]}, 32'h65);
      @(posedge ref_clk_i);
      pwm[0] <= 1'h0;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i); check("predischarge", {gate_sink[0], gate_code[5:0]}, 32'h41);
      repeat (5) @(posedge ref_clk_i);
      @(negedge ref_clk_i); check("discharge", {gate_sink[0], gate_code[5:0]}, 32'h5A);
      bus(1'h1, A_PWMEN, 32'h0);
      pwm[0] <= 1'h0;
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i); check("hard off", {gate_sink[0], gate_code[5:0]}, {25'h0, 1'h1, HARDOFF_CODE});
      check("fw hard off", {fw_sink[0], fw_code[5:0]}, {25'h0, 1'h1, HARDOFF_CODE});
      $display("test gate done");
   endtask
   task automatic t_filter();
      bus(1'h1, A_GEN, 32'h0E); bus(1'h1, A_IMAX, RST_IMAX); bus(1'h1, A_DINIT, RST_INIT); en(32'h1);
      pulse(); bus(1'h0, A_PCODE, 32'h0); check("filter first", rd & 32'hFF, 32'h10);
      @(negedge ref_clk_i); check("fw on", {fw_sink[0], fw_code[5:0]}, 32'h25);
      pulse(); bus(1'h0, A_PCODE, 32'h0); check("filter second", rd & 32'hFF, 32'h12);
      bus(1'h1, A_GEN, 32'h01); pulse();
      bus(1'h0, A_PCODE, 32'h0); check("select fixed", rd & 32'hFF, 32'h12);
      bus(1'h1, A_GEN, 32'h03); pulse();
      bus(1'h0, A_PCODE, 32'h0); check("select adapt", rd & 32'hFF, 32'h13);
      $display("test filter done");
   endtask
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1'h1;
      t_regs();
      t_load();
      t_adapt();
      t_clamp();
      t_gate();
      t_filter();
      stop_test();
   end
   // The full run needs about 1850 cycles, so this margin only trips on a hang.
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      errors++;
      stop_test();
   end
endmodule
